// ### src/cgt_pkg.sv
// constants, register map and types for the gate timing block
// assumes a 20 MHz pclk and an APB master with 32-bit data
package cgt_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int CNT_W = 16;
    localparam int FSW_KHZ = 250;
    localparam int DUTY_MAX_PCT = 78;
    localparam int BLANK_DEF_NS = 100;
    localparam int BLANK_PROG_NS = 100;
    localparam int DEAD_NS = 100;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    localparam logic [15:0] PERIOD_CYC = 16'(CLK_HZ / (FSW_KHZ * 1000));
    localparam logic [15:0] BLANK_DEF_CYC =
        16'((BLANK_DEF_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] BLANK_PROG_CYC =
        16'((BLANK_PROG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] DEAD_CYC = 16'((DEAD_NS * CLK_MHZ + 999) / 1000);

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_BLANK = 8'h08;
    localparam logic [7:0] OFS_DEAD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_AUXDIS_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    localparam int ST_MAIN_BIT = 0;
    localparam int ST_AUX_BIT = 1;
    localparam int ST_OT_BIT = 2;
    localparam int ST_ZD_BIT = 3;
    localparam int ST_BDEF_BIT = 4;
    localparam int ST_SYNC_BIT = 5;

    typedef enum logic [2:0] {
        CGT_IDLE,
        CGT_PRE_DEAD,
        CGT_MAIN,
        CGT_POST_DEAD,
        CGT_AUX,
        CGT_SYNC
    } cgt_state_t;

    // longest main on-time for a period, rounded down
    function automatic logic [15:0] cgt_max_on(input logic [15:0] per);
        logic [31:0] p;
        p = {16'h0000, per} * DUTY_MAX_PCT / 100;
        return p[15:0];
    endfunction

endpackage

// ### src/cgt_sync3.sv
// three-stage synchroniser for asynchronous pins
// assumes inputs are slow levels; a change is taken once stages 2 and 3 agree
module cgt_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // per bit: follow only where stage 2 and 3 agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
        end
    end

    assign q = q_reg;

endmodule

// ### src/cgt_gate_timing.sv
// complementary gate timing: oscillator, blanking, dead time, shutdown
// assumes APB master on pclk; comparator and pin inputs are asynchronous
//
// Operation
// - main on-time is cut at 78% of the oscillator period
// - slope only affects PWM path; current-limit trip ends on-time once blanking is over
// - comparators ignored while main low and during blanking
// - current-sense pull-down active whenever the main gate is low
// - blank pin high picks default blanking, low picks programmed value
// - blanking sets the minimum main on-time
// - same dead time both ways; the two drives never overlap
// - auxiliary drive turns off as each period starts
// - disable option puts the auxiliary output in high impedance
// - high means switch on for both drives; aux low in dead time
// - sync pulse ends on-time; off-time waits for the pulse end
// - free-runs at set period; sync pulse restarts period and limit
// - over-temperature stops bias, driver and forces undervoltage state
// - loop control below zero-duty offset stops switching
// - when disabled main gate low, enabled aux gate low
module cgt_gate_timing (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_trip,
    input wire logic ilim_trip,
    input wire logic osc_freq_pin,
    input wire logic over_temp_shutdown,
    input wire logic loop_control_below_offset,
    input wire logic blank_select_pin,
    output logic main_gate,
    output logic aux_gate_drive_o,
    output logic aux_gate_drive_oe,
    output logic cs_pulldown,
    output logic bias_reg_en,
    output logic uv_force
);
    import cgt_pkg::*;

    if (CNT_W != 16) begin : g_bad_width
        $error("cgt_gate_timing: counters must be 16 bits");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [5:0] pins_s;
    logic trip_pwm_s;
    logic trip_ilim_s;
    logic sync_s;
    logic ot_s;
    logic zd_s;
    logic bdef_s;

    cgt_sync3 #(.W(6)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({pwm_trip, ilim_trip, osc_freq_pin, over_temp_shutdown,
            loop_control_below_offset, blank_select_pin}),
        .q(pins_s)
    );

    assign {trip_pwm_s, trip_ilim_s, sync_s, ot_s, zd_s, bdef_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state

    logic [1:0] ctrl_reg;
    logic [15:0] period_reg;
    logic [15:0] blank_reg;
    logic [15:0] dead_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_next;
    logic hit_next;
    logic wr_go;
    logic [5:0] status;

    always_comb begin
        rd_next = 32'h00000000;
        hit_next = 1'b1;
        unique case (paddr)
            OFS_CTRL: rd_next = {30'h00000000, ctrl_reg};
            OFS_PERIOD: rd_next = {16'h0000, period_reg};
            OFS_BLANK: rd_next = {16'h0000, blank_reg};
            OFS_DEAD: rd_next = {16'h0000, dead_reg};
            OFS_STATUS: rd_next = {26'h0000000, status};
            default: hit_next = 1'b0;
        endcase
    end

    assign wr_go = psel & penable & pready_reg & pwrite & ~pslverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= psel & penable & ~pready_reg;
            pslverr_reg <= psel & penable & ~pready_reg & ~hit_next;
            if (psel & penable & ~pready_reg & ~pwrite) begin
                prdata_reg <= rd_next;
            end else begin
                prdata_reg <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            period_reg <= PERIOD_CYC;
            blank_reg <= BLANK_PROG_CYC;
            dead_reg <= DEAD_CYC;
        end else if (wr_go) begin
            unique case (paddr)
                OFS_CTRL: ctrl_reg <= pwdata[1:0];
                OFS_PERIOD: period_reg <= pwdata[15:0];
                OFS_BLANK: blank_reg <= pwdata[15:0];
                OFS_DEAD: dead_reg <= pwdata[15:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // switching sequencer

    cgt_state_t state_reg;
    cgt_state_t state_next;
    logic [15:0] tmr_reg;
    logic [15:0] per_reg;
    logic sync_d_reg;
    logic run;
    logic aux_dis;
    logic per_start;
    logic sync_rise;
    logic [15:0] blank_cyc;
    logic [15:0] max_on;
    logic blank_done;
    logic dead_done;
    logic cut;

    assign run = ctrl_reg[CTRL_RUN_BIT] & ~ot_s & ~zd_s;
    assign aux_dis = ctrl_reg[CTRL_AUXDIS_BIT];
    assign blank_cyc = bdef_s ? BLANK_DEF_CYC : blank_reg;
    assign max_on = cgt_max_on(period_reg);
    assign blank_done = tmr_reg >= blank_cyc;
    assign dead_done = (tmr_reg + 16'h0001) >= dead_reg;
    assign per_start = (per_reg + 16'h0001) >= period_reg;
    assign sync_rise = sync_s & ~sync_d_reg;
    // trips only count after blanking; duty ceiling
    assign cut = ((trip_pwm_s | trip_ilim_s) & blank_done)
        | ((tmr_reg + 16'h0001) >= max_on);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CGT_IDLE: state_next = CGT_PRE_DEAD;
            CGT_PRE_DEAD: if (dead_done) begin
                state_next = CGT_MAIN;
            end
            CGT_MAIN: if (cut) begin
                state_next = CGT_POST_DEAD;
            end
            CGT_POST_DEAD: if (dead_done) begin
                state_next = CGT_AUX;
            end
            CGT_AUX: state_next = CGT_AUX;
            CGT_SYNC: if (!sync_s) begin
                state_next = CGT_PRE_DEAD;
            end
        endcase
        if (!run) begin
            state_next = CGT_IDLE;
        end else if (sync_rise) begin
            state_next = CGT_SYNC;
        end else if (per_start && state_reg != CGT_IDLE
                     && state_reg != CGT_SYNC) begin
            state_next = CGT_PRE_DEAD;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CGT_IDLE;
            sync_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sync_d_reg <= sync_s;
        end
    end

    // one timer serves dead time and on-time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_reg <= 16'h0000;
        end else if (state_next != state_reg) begin
            tmr_reg <= 16'h0000;
        end else if (tmr_reg != 16'hFFFF) begin
            tmr_reg <= tmr_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_reg <= 16'h0000;
        end else if (state_next == CGT_IDLE || state_next == CGT_SYNC
                     || state_reg == CGT_SYNC || per_start) begin
            per_reg <= 16'h0000;
        end else begin
            per_reg <= per_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output drivers

    logic main_reg;
    logic aux_o_reg;
    logic aux_oe_reg;
    logic pd_reg;
    logic bias_reg;
    logic uv_reg;

    // high turns a switch on; pull-down while main low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_reg <= 1'b0;
            pd_reg <= 1'b1;
        end else begin
            main_reg <= state_next == CGT_MAIN;
            pd_reg <= state_next != CGT_MAIN;
        end
    end

    // disable floats aux; low when enabled and idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_o_reg <= 1'b0;
            aux_oe_reg <= 1'b1;
        end else begin
            aux_o_reg <= (state_next == CGT_AUX) & ~aux_dis;
            aux_oe_reg <= ~aux_dis;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_reg <= 1'b0;
            uv_reg <= 1'b1;
        end else begin
            bias_reg <= ~ot_s;
            uv_reg <= ot_s;
        end
    end

    assign main_gate = main_reg;
    assign aux_gate_drive_o = aux_o_reg;
    assign aux_gate_drive_oe = aux_oe_reg;
    assign cs_pulldown = pd_reg;
    assign bias_reg_en = bias_reg;
    assign uv_force = uv_reg;
    assign status = {sync_s, bdef_s, zd_s, ot_s, aux_o_reg, main_reg};

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [15:0] hi_cnt_reg;
    logic [15:0] gap_cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_reg <= 16'h0000;
            gap_cnt_reg <= 16'h0000;
        end else begin
            hi_cnt_reg <= main_reg ? hi_cnt_reg + 16'h0001 : 16'h0000;
            if (main_reg | aux_o_reg) begin
                gap_cnt_reg <= 16'h0000;
            end else if (gap_cnt_reg != 16'hFFFF) begin
                gap_cnt_reg <= gap_cnt_reg + 16'h0001;
            end
        end
    end

    property p_duty_max;
        @(posedge pclk) disable iff (!presetn)
        main_reg |-> hi_cnt_reg < max_on;
    endproperty
    a_duty_max: assert property (p_duty_max) else $error("on-time too long");

    property p_min_on;
        @(posedge pclk) disable iff (!presetn)
        $fell(main_reg) && $past(run) && !$past(sync_rise)
            && !$past(per_start) |-> $past(hi_cnt_reg) >= blank_cyc;
    endproperty
    a_min_on: assert property (p_min_on) else $error("blanking cut short");

    property p_pulldown;
        @(posedge pclk) disable iff (!presetn)
        pd_reg != main_reg;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down wrong");

    property p_no_overlap;
        @(posedge pclk) disable iff (!presetn)
        !(main_reg && aux_o_reg);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");

    property p_dead_gap;
        @(posedge pclk) disable iff (!presetn)
        ($rose(main_reg) || $rose(aux_o_reg))
            |-> $past(gap_cnt_reg) + 16'h0001 >= dead_reg;
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("dead time short");

    sequence s_period_edge;
        run && per_start && state_reg == CGT_AUX;
    endsequence

    property p_aux_off;
        @(posedge pclk) disable iff (!presetn)
        s_period_edge |=> !aux_o_reg ##1 !aux_o_reg;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux on at period");

    property p_aux_float;
        @(posedge pclk) disable iff (!presetn)
        aux_dis |=> !aux_oe_reg && !aux_o_reg;
    endproperty
    a_aux_float: assert property (p_aux_float) else $error("aux not floated");

    sequence s_sync_pulse;
        run && sync_rise;
    endsequence

    property p_sync_end;
        @(posedge pclk) disable iff (!presetn)
        s_sync_pulse |=> !main_reg && !aux_o_reg;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("sync not honoured");

    property p_ot_stop;
        @(posedge pclk) disable iff (!presetn)
        ot_s |=> uv_reg && !bias_reg && !main_reg;
    endproperty
    a_ot_stop: assert property (p_ot_stop) else $error("no thermal stop");

    property p_zero_duty;
        @(posedge pclk) disable iff (!presetn)
        zd_s |=> !main_reg && !aux_o_reg;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty runs");

endmodule

// ### verification/cgt_switch_model.sv
// far-side model: main and auxiliary switches with sense comparators
// assumes trip levels are given in cycles of main on-time
module cgt_switch_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic main_gate,
    input wire logic aux_gate_drive_o,
    input wire logic aux_gate_drive_oe,
    input wire logic [15:0] pwm_level,
    input wire logic [15:0] ilim_level,
    output logic pwm_trip,
    output logic ilim_trip,
    output logic shoot_through
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] ramp_reg;

    // sensed current ramps while the main switch conducts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_reg <= 16'h0000;
        end else if (main_gate) begin
            ramp_reg <= ramp_reg + 16'h0001;
        end else begin
            ramp_reg <= 16'h0000;
        end
    end

    assign ilim_trip = main_gate && (ramp_reg >= ilim_level);
    assign pwm_trip = main_gate && ((ramp_reg + 16'h0001) >= pwm_level);
    assign shoot_through = main_gate && aux_gate_drive_oe && aux_gate_drive_o;
endmodule

// ### verification/cgt_gate_timing_tb.sv
// self-checking bench for the complementary gate timing block
// assumes the switch model drives both comparator pins
module cgt_gate_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cgt_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic osc_freq_pin = 1'b0;
    logic over_temp_shutdown = 1'b0;
    logic loop_control_below_offset = 1'b0;
    logic blank_select_pin = 1'b1;
    logic [15:0] pwm_level = 16'hFFFF;
    logic [15:0] ilim_level = 16'hFFFF;
    logic [31:0] prdata, q;
    logic pready, pslverr, pwm_trip, ilim_trip, shoot_through, err;
    logic main_gate, aux_o, aux_oe, cs_pulldown, bias_reg_en, uv_force;
    logic prev_main = 1'b0;
    logic prev_aux = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;
    int on_len = 0;
    int gap = 0;
    int per_len = 0;
    int last_on, last_per, last_gap, per, dd, lv;
    int dead_exp = 2;
    int max_exp = 62;

    always #25 pclk = ~pclk;

    cgt_gate_timing uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_trip(pwm_trip), .ilim_trip(ilim_trip),
        .osc_freq_pin(osc_freq_pin), .over_temp_shutdown(over_temp_shutdown),
        .loop_control_below_offset(loop_control_below_offset),
        .blank_select_pin(blank_select_pin), .main_gate(main_gate),
        .aux_gate_drive_o(aux_o), .aux_gate_drive_oe(aux_oe),
        .cs_pulldown(cs_pulldown), .bias_reg_en(bias_reg_en),
        .uv_force(uv_force));

    cgt_switch_model sw (.pclk(pclk), .presetn(presetn),
        .main_gate(main_gate), .aux_gate_drive_o(aux_o),
        .aux_gate_drive_oe(aux_oe), .pwm_level(pwm_level),
        .ilim_level(ilim_level), .pwm_trip(pwm_trip), .ilim_trip(ilim_trip),
        .shoot_through(shoot_through));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) mismatches++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("read", q, exp);
    endtask

    // stop, program and restart, then let three periods settle
    task automatic cfg(input int p, input int b, input int d,
                       input logic [31:0] c);
        apb(1'b1, OFS_CTRL, 32'h0);
        repeat (10) @(posedge pclk);
        max_exp = p * DUTY_MAX_PCT / 100;
        dead_exp = (d == 0) ? 1 : d;
        apb(1'b1, OFS_PERIOD, p);
        apb(1'b1, OFS_BLANK, b);
        apb(1'b1, OFS_DEAD, d);
        apb(1'b1, OFS_CTRL, c);
        repeat (3 * p + 20) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (presetn) begin
            check("overlap", shoot_through, 1'b0);
            if (main_gate === prev_main) begin
                check("pulldown", cs_pulldown, !main_gate);
            end
            if (!main_gate && !aux_o) begin
                gap++;
            end else if (!prev_main && !prev_aux) begin
                check("dead_min", gap >= dead_exp, 1'b1);
                last_gap = gap;
                gap = 0;
            end
            if (main_gate) begin
                on_len++;
            end else begin
                if (prev_main) begin
                    last_on = on_len;
                    check("on_max", last_on <= max_exp, 1'b1);
                end
                on_len = 0;
            end
            per_len++;
            if (main_gate && !prev_main) begin
                last_per = per_len;
                per_len = 0;
            end
            prev_main = main_gate;
            prev_aux = aux_o;
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hDAA9BF4E));
        repeat (2) @(posedge pclk);
        check("rst_main", main_gate, 1'b0);
        check("rst_pd", cs_pulldown, 1'b1);
        check("rst_uv", uv_force, 1'b1);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_PERIOD, 32'h50);
        rd(OFS_BLANK, 32'h2);
        rd(OFS_DEAD, 32'h2);
        rd(OFS_STATUS, 32'h10);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", err, 1'b1);
        cfg(80, 2, 2, 32'h1);
        check("period", last_per, 80);
        check("on_full", last_on, max_exp);
        check("gap_start", last_gap, dead_exp);
        for (int i = 0; i < 4; i++) begin
            per = 40 + $urandom_range(80);
            dd = (i == 0) ? 0 : $urandom_range(6, 1);
            lv = 10 + $urandom_range(15);
            pwm_level <= 16'(lv);
            cfg(per, 2, dd, 32'h1);
            check("per_rand", last_per, per);
            check("gap_rand", last_gap, dead_exp);
            check("on_pwm", last_on >= lv && last_on <= lv + 7, 1'b1);
        end
        pwm_level <= 16'hFFFF;
        ilim_level <= 16'h0000;
        blank_select_pin <= 1'b0;
        cfg(80, 20, 2, 32'h1);
        check("blank_prog", last_on >= 20 && last_on <= 27, 1'b1);
        blank_select_pin <= 1'b1;
        repeat (300) @(posedge pclk);
        check("blank_def", last_on <= 8, 1'b1);
        check("per_ilim", last_per, 80);
        apb(1'b1, OFS_CTRL, 32'h3);
        repeat (10) @(posedge pclk);
        check("aux_hiz", aux_oe, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h1);
        repeat (10) @(posedge pclk);
        check("aux_drv", aux_oe, 1'b1);
        ilim_level <= 16'hFFFF;
        for (int n = 0; n < 200 && main_gate !== 1'b1; n++) @(posedge pclk);
        osc_freq_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        check("sync_end", main_gate | aux_o, 1'b0);
        repeat (30) @(posedge pclk);
        check("sync_hold", main_gate | aux_o, 1'b0);
        osc_freq_pin <= 1'b0;
        repeat (200) @(posedge pclk);
        check("sync_resume", last_per, 80);
        loop_control_below_offset <= 1'b1;
        repeat (100) @(posedge pclk);
        check("zero_duty", main_gate | aux_o, 1'b0);
        loop_control_below_offset <= 1'b0;
        over_temp_shutdown <= 1'b1;
        repeat (100) @(posedge pclk);
        check("ot_bias", bias_reg_en, 1'b0);
        check("ot_uv", uv_force, 1'b1);
        check("ot_gates", main_gate | aux_o, 1'b0);
        over_temp_shutdown <= 1'b0;
        repeat (100) @(posedge pclk);
        check("ot_back", bias_reg_en, 1'b1);
        results();
    end
endmodule
